// ---- spc_core.sv ----
// Serial port controller: APB registers, pin control, transfer engine
`timescale 1ns/1ps
//
// Contract
// R1: Slave drives data only when selected
// R2: Deselected slave leaves data-out pin floating
// R3: Enabled port owns direction of shared pins
// R4: Master drives clock; slave takes it; 8 cycles
// R5: Master shifts out and in together
// R6: Phase 0 needs select toggled per byte
// R7: Slave always uses select as input
// R8: Deselected slave ignores all clock edges
// R9: Select pin used by master only with detect
// R10: Pin levels readable through port register
// R11: Receive enable gates receive request; reset clears
// R12: Master-select bit picks mode; resets to one
// R13: Polarity sets idle clock level; reset clears
// R14: Phase sets data timing; reset sets
// R15: Wired-or makes pins open-drain, no pullups; code does so only for miso, mosi and sck, and only while enabled
// R16: Enable bit; clearing it partially resets
// R17: Transmit-empty set on load; gated request
// R18: Receive-full set on load; two-step clear
// R19: Error enable gates fault and overrun
// R20: Overrun keeps old byte, drops new
// R21: Overrun cleared by status then data read
// R22: Mode fault on slave or master select
// R23: Mode fault cleared by status then control write
// R24: Rate code picks divisor 2, 8, 32, 128
// R25: Bytes shift most significant bit first
// R26: Status read arms the later clear
module spc_core
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared pins, index order miso, mosi, sck, ss
  input wire logic [3:0] pinIn,
  output logic [3:0] pinOut,
  output logic [3:0] pinOen,
  output logic pullupEn,
  // Interrupt requests to the CPU
  output logic rxIrq,
  output logic txIrq,
  output logic errIrq
);

  typedef struct packed {
    spc_xfer_t xfer;     // Engine state
    logic [7:0] ctrl;    // serial_control
    logic error_irq_enable;         // Error request enable
    logic fden;          // fault_detect_enable
    logic [1:0] rate;    // Rate select high/low
    logic rxFull;        // rx_full_flag
    logic ovr;           // overrun_flag
    logic mode_fault_flag;          // mode_fault_flag
    logic txEmpty;       // tx_empty_flag
    logic [7:0] txData;  // Transmit holding register
    logic [7:0] rxData;  // Receive data register
    logic [7:0] txSh;    // Outgoing shift register
    logic [7:0] rxSh;    // Incoming shift register
    logic outBit;        // Bit currently on the data-out pin
    logic sckLvl;        // Master serial clock level
    logic [4:0] edgeCnt; // Serial clock edges seen this byte
    logic armRx;         // Status read saw receive-full
    logic armOvr;        // Status read saw overrun
    logic armModf;       // Status read saw mode fault
    logic ssPrev;        // Select level last cycle
    logic sckPrev;       // Clock level last cycle
    logic [3:0] portOut; // General-purpose output data
    logic [3:0] portDir; // General-purpose direction, 1 = out
    logic [31:0] rdData; // Read data for the access phase
  } spc_core_state_t;

  spc_core_state_t s;
  spc_core_state_t next_s;

  logic [3:0] pinS;   // Synchronised pin levels
  logic tick;         // Master half-period tick
  logic en;           // Port enabled
  logic mstr;         // Master mode selected
  logic ssS;          // Synchronised select, active low
  logic sckS;         // Synchronised serial clock
  logic slaveSel;     // Enabled slave with select low
  logic ssUsed;       // Select pin belongs to the port
  logic accessDone;   // APB access phase completes
  logic setupRd;      // APB setup phase of a read

  // Pins arrive from outside the clock domain
  spc_sync #(.W(SPC_NPINS)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async(pinIn),
    .synced(pinS)
  );

  // Baud tick only while the master engine runs
  spc_rate #(.W(8)) u_rate (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(s.xfer == SPC_MRUN),
    .rateSel(s.rate), // R24
    .tick(tick)
  );

  assign en = s.ctrl[SPC_CTL_EN];
  assign mstr = s.ctrl[SPC_CTL_MSTR];
  assign ssS = pinS[SPC_PIN_SS];
  assign sckS = pinS[SPC_PIN_SCK];
  assign slaveSel = en && !mstr && !ssS; // R1
  assign ssUsed = en && (!mstr || s.fden); // R7 R9
  assign accessDone = psel && penable;
  assign setupRd = psel && !penable && !pwrite;

  // Zero-wait slave: answer in the first access cycle
  assign pready = accessDone;
  assign pslverr = accessDone && (paddr[1:0] != 2'h0 ||
    (paddr != SPC_OFS_CTRL && paddr != SPC_OFS_STAT &&
     paddr != SPC_OFS_DATA && paddr != SPC_OFS_PORT));
  assign prdata = s.rdData;

  // Status register image as software sees it
  function automatic logic [7:0] statImage(spc_core_state_t v);
    logic [7:0] r;
    r = '0;
    r[SPC_ST_RXF] = v.rxFull;
    r[SPC_ST_ERROR_IRQ_ENABLE] = v.error_irq_enable;
    r[SPC_ST_OVR] = v.ovr;
    r[SPC_ST_MODE_FAULT_FLAG] = v.mode_fault_flag;
    r[SPC_ST_TXE] = v.txEmpty;
    r[SPC_ST_FDEN] = v.fden;
    r[SPC_ST_RHI] = v.rate[1];
    r[SPC_ST_RLO] = v.rate[0];
    return r;
  endfunction

  // Requests; receive ignores enable, transmit needs it
  assign rxIrq = s.ctrl[SPC_CTL_RXIE] && s.rxFull; // R11 R18
  assign txIrq = s.ctrl[SPC_CTL_TXIE] && s.txEmpty && en; // R17
  assign errIrq = s.error_irq_enable && (s.mode_fault_flag || s.ovr); // R19

  // Register access first, then the engine, so flag sets win
  always_comb begin
    logic capture;
    logic inBit;
    capture = 1'b0;
    inBit = 1'b0;
    next_s = s;
    next_s.ssPrev = ssS;
    next_s.sckPrev = sckS;

    // Read data is captured in setup so it leaves a flop
    if (setupRd) begin
      case (paddr)
        SPC_OFS_CTRL: next_s.rdData = {24'h0, s.ctrl};
        SPC_OFS_STAT: next_s.rdData = {24'h0, statImage(s)};
        SPC_OFS_DATA: next_s.rdData = {24'h0, s.rxData};
        SPC_OFS_PORT: next_s.rdData = {20'h0, pinS, s.portDir,
                                       s.portOut}; // R10
        default: next_s.rdData = '0;
      endcase
    end

    // Side effects happen when the access completes
    if (accessDone && !pwrite) begin
      if (paddr == SPC_OFS_STAT) begin
        // Remember which flags the CPU has seen set
        next_s.armRx = s.rdData[SPC_ST_RXF]; // R26
        next_s.armOvr = s.rdData[SPC_ST_OVR]; // R26
        next_s.armModf = s.rdData[SPC_ST_MODE_FAULT_FLAG]; // R26
      end else if (paddr == SPC_OFS_DATA) begin
        // Second step of the receive and overrun clears
        if (s.armRx) begin
          next_s.rxFull = 1'b0; // R18
        end
        if (s.armOvr) begin
          next_s.ovr = 1'b0; // R21
        end
        next_s.armRx = 1'b0;
        next_s.armOvr = 1'b0;
      end
    end else if (accessDone && pwrite) begin
      case (paddr)
        SPC_OFS_CTRL: begin
          next_s.ctrl = pwdata[7:0]; // R12 R13 R14 R15 R16
          if (s.armModf) begin
            next_s.mode_fault_flag = 1'b0; // R23
          end
          next_s.armModf = 1'b0;
        end
        SPC_OFS_STAT: begin
          // Only the control bits are writable here
          next_s.error_irq_enable = pwdata[SPC_ST_ERROR_IRQ_ENABLE];
          next_s.fden = pwdata[SPC_ST_FDEN];
          next_s.rate = {pwdata[SPC_ST_RHI], pwdata[SPC_ST_RLO]};
        end
        SPC_OFS_DATA: begin
          // A data write is the only clear of transmit-empty
          next_s.txData = pwdata[7:0];
          next_s.txEmpty = 1'b0;
        end
        SPC_OFS_PORT: begin
          next_s.portOut = pwdata[3:0];
          next_s.portDir = pwdata[7:4];
        end
        default: begin
          next_s.portOut = s.portOut;
        end
      endcase
    end

    // Transfer engine
    if (!next_s.ctrl[SPC_CTL_EN]) begin
      // Partial reset: abort, clear shifter, transmitter empty
      next_s.xfer = SPC_IDLE; // R16
      next_s.txEmpty = 1'b1;
      next_s.txSh = '0;
      next_s.rxSh = '0;
      next_s.edgeCnt = '0;
      next_s.outBit = 1'b0;
      next_s.sckLvl = next_s.ctrl[SPC_CTL_POL]; // R13
    end else if (next_s.ctrl[SPC_CTL_MSTR]) begin
      // Master: an active select with detection is a fault
      if (s.fden && !ssS) begin
        next_s.mode_fault_flag = 1'b1; // R22
        next_s.ctrl[SPC_CTL_EN] = 1'b0;
        next_s.xfer = SPC_IDLE;
        next_s.edgeCnt = '0;
        next_s.sckLvl = next_s.ctrl[SPC_CTL_POL];
      end else if (s.xfer != SPC_MRUN) begin
        next_s.xfer = SPC_IDLE;
        next_s.edgeCnt = '0;
        next_s.sckLvl = next_s.ctrl[SPC_CTL_POL]; // R13
        if (!next_s.txEmpty) begin
          // Move the byte into the shifter and start
          next_s.txSh = next_s.txData;
          next_s.txEmpty = 1'b1; // R17
          next_s.xfer = SPC_MRUN;
          if (!next_s.ctrl[SPC_CTL_PHA]) begin
            // Phase 0 presents the first bit before any edge
            next_s.outBit = next_s.txSh[7]; // R14 R25
            next_s.txSh = {next_s.txSh[6:0], 1'b0};
          end
        end
      end else if (tick) begin
        next_s.sckLvl = !s.sckLvl; // R4
        capture = (s.edgeCnt[0] == next_s.ctrl[SPC_CTL_PHA]);
        inBit = pinS[SPC_PIN_MISO]; // R5
      end
    end else begin
      // Slave: deselect aborts and may flag a fault
      if (ssS) begin
        if (s.xfer == SPC_SRUN && s.fden) begin
          next_s.mode_fault_flag = 1'b1; // R22
        end
        next_s.xfer = SPC_IDLE; // R8
        next_s.edgeCnt = '0;
      end else if (s.xfer != SPC_SRUN) begin
        next_s.xfer = SPC_IDLE;
        // Phase 0 starts at select fall, phase 1 at first edge
        if ((!next_s.ctrl[SPC_CTL_PHA] && s.ssPrev) ||
            (next_s.ctrl[SPC_CTL_PHA] && sckS != s.sckPrev &&
             sckS != next_s.ctrl[SPC_CTL_POL])) begin
          next_s.xfer = SPC_SRUN;
          next_s.edgeCnt = '0;
          if (!next_s.txEmpty) begin
            next_s.txSh = next_s.txData;
            next_s.txEmpty = 1'b1; // R17
          end
          next_s.outBit = next_s.txSh[7]; // R25
          next_s.txSh = {next_s.txSh[6:0], 1'b0};
          if (next_s.ctrl[SPC_CTL_PHA]) begin
            // This leading edge was the launch edge
            next_s.edgeCnt = 5'h01;
          end
        end
      end else if (sckS != s.sckPrev) begin
        capture = (s.edgeCnt[0] == next_s.ctrl[SPC_CTL_PHA]);
        inBit = pinS[SPC_PIN_MOSI];
      end
    end

    // Common edge handling for both running states
    if (next_s.xfer == s.xfer && s.xfer != SPC_IDLE &&
        next_s.ctrl[SPC_CTL_EN] &&
        ((s.xfer == SPC_MRUN && tick) ||
         (s.xfer == SPC_SRUN && !ssS && sckS != s.sckPrev))) begin
      if (capture) begin
        next_s.rxSh = {s.rxSh[6:0], inBit}; // R25
      end else begin
        next_s.outBit = next_s.txSh[7];
        next_s.txSh = {next_s.txSh[6:0], 1'b0};
      end
      next_s.edgeCnt = s.edgeCnt + 5'h01;
      if (next_s.edgeCnt == SPC_EDGES) begin
        // Byte complete after eight clock cycles
        next_s.xfer = SPC_IDLE; // R4
        next_s.edgeCnt = '0;
        if (next_s.rxFull) begin
          next_s.ovr = 1'b1; // R20
        end else begin
          next_s.rxData = next_s.rxSh;
          next_s.rxFull = 1'b1; // R18
        end
      end
    end
  end

  // State register; reset restores every control bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.xfer <= SPC_IDLE;
      s.ctrl <= SPC_CTRL_RST; // R11 R12 R13 R14 R16
      s.txEmpty <= SPC_STAT_RST[SPC_ST_TXE];
      s.ssPrev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Pin drive; enable low means the pin is driven
  always_comb begin
    logic wiredOr;
    wiredOr = s.ctrl[SPC_CTL_WOR];
    // Port default when the block does not own a pin
    for (int i = 0; i < SPC_NPINS; i++) begin
      pinOut[i] = s.portOut[i];
      pinOen[i] = !s.portDir[i];
    end
    if (en) begin
      // Direction of miso, mosi and sck follows the mode, not the port register
      if (mstr) begin
        pinOut[SPC_PIN_SCK] = s.sckLvl; // R3 R4
        pinOen[SPC_PIN_SCK] = 1'b0;
        pinOut[SPC_PIN_MOSI] = s.outBit; // R5
        pinOen[SPC_PIN_MOSI] = 1'b0;
        pinOut[SPC_PIN_MISO] = 1'b0;
        pinOen[SPC_PIN_MISO] = 1'b1;
      end else begin
        pinOut[SPC_PIN_SCK] = 1'b0;
        pinOen[SPC_PIN_SCK] = 1'b1; // R4
        pinOut[SPC_PIN_MOSI] = 1'b0;
        pinOen[SPC_PIN_MOSI] = 1'b1;
        pinOut[SPC_PIN_MISO] = s.outBit;
        pinOen[SPC_PIN_MISO] = !slaveSel; // R1 R2
      end
      if (ssUsed) begin
        pinOut[SPC_PIN_SS] = 1'b0;
        pinOen[SPC_PIN_SS] = 1'b1; // R7 R9
      end
      // Open-drain: pull low only, release for a one
      if (wiredOr) begin
        for (int i = 0; i < 3; i++) begin
          if (!pinOen[i] && pinOut[i]) begin
            pinOen[i] = 1'b1; // R15
          end
          pinOut[i] = 1'b0;
        end
      end
    end
  end

  // Pullups go off in wired-or mode while the port is enabled
  assign pullupEn = !(en && s.ctrl[SPC_CTL_WOR]); // R15
endmodule

// ---- spc_core_asserts.sv ----
// Port-level assertions for the serial port controller
`timescale 1ns/1ps
module spc_core_asserts
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] pinIn,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOen,
  input wire logic pullupEn,
  input wire logic rxIrq,
  input wire logic txIrq,
  input wire logic errIrq
);
  // One clock domain, so one default clocking serves all
  default clocking cb @(posedge clk); endclocking

  // Zero wait states: access phase is always answered at once
  a_ready_access: assert property (disable iff (sys_rst)
    psel && penable |-> pready) else $error("access phase not ready");
  // No answer and no error outside a selected transfer
  a_quiet_idle: assert property (disable iff (sys_rst)
    !psel |-> !pready && !pslverr) else $error("answer while idle");
  // Unaligned addresses are refused
  a_refuse_unaligned: assert property (disable iff (sys_rst)
    psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access accepted");
  // Addresses above the last register are refused
  a_refuse_unmapped: assert property (disable iff (sys_rst)
    psel && penable && paddr > SPC_OFS_PORT |-> pslverr)
    else $error("unmapped access accepted");
  // Registers are eight bits wide; only the port image fills 11:8
  a_upper_zero: assert property (disable iff (sys_rst)
    psel && penable && !pwrite |-> prdata[31:12] == 20'h00000 &&
    (paddr == SPC_OFS_PORT || prdata[11:8] == 4'h0))
    else $error("upper read bits set");
  // Reset clears every interrupt enable, so no request follows even with transmit-empty set
  a_irq_reset: assert property (
    sys_rst |=> !rxIrq && !txIrq && !errIrq)
    else $error("interrupt request after reset");
  // Reset hands all pins back to the port as inputs, pullups on
  a_pins_reset: assert property (
    sys_rst |=> pinOen == 4'hf && pullupEn)
    else $error("pins not released by reset");
  // A driven serial clock never toggles on two clocks in a row
  a_sck_half: assert property (disable iff (sys_rst)
    !pinOen[SPC_PIN_SCK] && $past(!pinOen[SPC_PIN_SCK])
    && $changed(pinOut[SPC_PIN_SCK]) |=> $stable(pinOut[SPC_PIN_SCK]))
    else $error("serial clock half period too short");
endmodule

bind spc_core spc_core_asserts spc_core_asserts_inst (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
  .pinOen(pinOen), .pullupEn(pullupEn), .rxIrq(rxIrq), .txIrq(txIrq),
  .errIrq(errIrq)
);

// ---- spc_peer.sv ----
// Behavioural far-side serial slave, polarity 0 and phase 1
`timescale 1ns/1ps
module spc_peer (
  input wire logic sck,
  input wire logic mosi,
  input wire logic selN,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [7:0] shift; // Outgoing byte, top bit leads
  int bitCnt; // Bits taken in the current byte

  initial begin
    shift = 8'h00;
    bitCnt = 0;
    miso = 1'b1;
    rxByte = 8'h00;
  end

  // Leading edge launches the next bit; idle level is low
  always @(posedge sck) begin
    if (!selN) begin
      if (bitCnt == 0)
        shift = txByte;
      miso = shift[7];
      shift = {shift[6:0], 1'b0};
    end
  end

  // Trailing edge captures, eight cycles make one byte
  always @(negedge sck) begin
    if (!selN) begin
      rxByte = {rxByte[6:0], mosi};
      bitCnt = (bitCnt + 1) % 8;
    end
  end

  // A released line shows the opposite level, so stale bits never match
  always @(posedge selN) miso = ~miso;
endmodule

// ---- spc_pkg.sv ----
// Shared constants and types for the serial port controller
package spc_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] SPC_OFS_CTRL = 8'h00;
  localparam logic [7:0] SPC_OFS_STAT = 8'h04;
  localparam logic [7:0] SPC_OFS_DATA = 8'h08;
  localparam logic [7:0] SPC_OFS_PORT = 8'h0c;

  // serial_control field positions
  localparam int SPC_CTL_RXIE = 7;
  localparam int SPC_CTL_MSTR = 5;
  localparam int SPC_CTL_POL = 4;
  localparam int SPC_CTL_PHA = 3;
  localparam int SPC_CTL_WOR = 2;
  localparam int SPC_CTL_EN = 1;
  localparam int SPC_CTL_TXIE = 0;

  // serial_status_and_control field positions
  localparam int SPC_ST_RXF = 7;
  localparam int SPC_ST_ERROR_IRQ_ENABLE = 6;
  localparam int SPC_ST_OVR = 5;
  localparam int SPC_ST_MODE_FAULT_FLAG = 4;
  localparam int SPC_ST_TXE = 3;
  localparam int SPC_ST_FDEN = 2;
  localparam int SPC_ST_RHI = 1;
  localparam int SPC_ST_RLO = 0;

  // Reset values of the two control registers
  localparam logic [7:0] SPC_CTRL_RST = 8'h28;
  localparam logic [7:0] SPC_STAT_RST = 8'h08;

  // Shared pin indices (port bit order)
  localparam int SPC_NPINS = 4;
  localparam int SPC_PIN_MISO = 0;
  localparam int SPC_PIN_MOSI = 1;
  localparam int SPC_PIN_SCK = 2;
  localparam int SPC_PIN_SS = 3;

  // Baud divisors for rate codes 00..11
  localparam logic [7:0] SPC_BD0 = 8'h02;
  localparam logic [7:0] SPC_BD1 = 8'h08;
  localparam logic [7:0] SPC_BD2 = 8'h20;
  localparam logic [7:0] SPC_BD3 = 8'h80;

  // Serial clock edges per byte: eight full cycles
  localparam logic [4:0] SPC_EDGES = 5'h10;

  // Transfer engine states, one-hot
  typedef enum logic [2:0] {
    SPC_IDLE = 3'b001,
    SPC_MRUN = 3'b010,
    SPC_SRUN = 3'b100
  } spc_xfer_t;

endpackage

// ---- spc_rate.sv ----
// Master baud tick generator: one tick every divisor clocks
`timescale 1ns/1ps
module spc_rate
  import spc_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [1:0] rateSel,
  output logic tick
);

  typedef struct packed {
    logic [W-1:0] cnt; // Clocks since last serial clock edge
  } spc_rate_state_t;

  spc_rate_state_t s;
  spc_rate_state_t next_s;
  logic [W-1:0] bd; // Selected divisor

  // Divisor lookup; a tick is half a serial clock period
  always_comb begin
    case (rateSel)
      2'h0: bd = W'(SPC_BD0);
      2'h1: bd = W'(SPC_BD1);
      2'h2: bd = W'(SPC_BD2);
      default: bd = W'(SPC_BD3);
    endcase
  end

  assign tick = run && (s.cnt == bd - W'(1));

  // Counter restarts whenever the engine is not running
  always_comb begin
    next_s = s;
    if (!run || tick) begin
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ---- spc_sync.sv ----
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module spc_sync
  import spc_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] meta; // First stage, read only by the second
    logic [W-1:0] sync; // Second stage, safe to use
  } spc_sync_state_t;

  spc_sync_state_t s;
  spc_sync_state_t next_s;

  // Shift the pin levels through both stages
  always_comb begin
    next_s.meta = async;
    next_s.sync = s.meta;
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign synced = s.sync;
endmodule

// ---- spc_tb.sv ----
// Self-checking testbench for the serial port controller
`timescale 1ns/1ps
module testbench
  import spc_pkg::*;
;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [31:0] exp;
    logic err;
  } spc_row_t;

  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pinIn, pinOut, pinOen;
  logic pullupEn, rxIrq, txIrq, errIrq;
  // Select line, driven by the bench as the far master; set before
  // any process starts so no false edge reaches the peer
  logic selN = 1'b1;
  logic peerMiso;
  logic [7:0] peerTx, peerRx;
  int num_errors = 0;
  int compares = 0;

  // Register table rows: reset values, access kinds, refusals
  spc_row_t rows [11] = '{
    '{1'b0, SPC_OFS_CTRL, 8'h00, 32'h28, 1'b0},
    '{1'b0, SPC_OFS_STAT, 8'h00, 32'h08, 1'b0},
    '{1'b0, SPC_OFS_PORT, 8'h00, 32'hb00, 1'b0},
    '{1'b0, SPC_OFS_DATA, 8'h00, 32'h00, 1'b0},
    '{1'b1, SPC_OFS_CTRL, 8'h9d, 32'h00, 1'b0},
    '{1'b0, SPC_OFS_CTRL, 8'h00, 32'h9d, 1'b0},
    '{1'b1, SPC_OFS_STAT, 8'hff, 32'h00, 1'b0},
    '{1'b0, SPC_OFS_STAT, 8'h00, 32'h4f, 1'b0},
    '{1'b0, 8'h10, 8'h00, 32'h00, 1'b1},
    '{1'b1, 8'h02, 8'hff, 32'h00, 1'b1},
    '{1'b0, SPC_OFS_CTRL, 8'h00, 32'h9d, 1'b0}};

  // Pad levels: the bench idles the clock low, mosi has a pullup
  assign pinIn = {selN, pinOen[2] ? 1'b0 : pinOut[2],
    pinOen[1] ? 1'b1 : pinOut[1], pinOen[0] ? peerMiso : pinOut[0]};

  spc_core spc_core_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
    .pinOut(pinOut), .pinOen(pinOen), .pullupEn(pullupEn),
    .rxIrq(rxIrq), .txIrq(txIrq), .errIrq(errIrq));

  spc_peer spc_peer_inst (.sck(pinIn[SPC_PIN_SCK]),
    .mosi(pinIn[SPC_PIN_MOSI]), .selN(selN), .txByte(peerTx),
    .miso(peerMiso), .rxByte(peerRx));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare and count; case equality so unknowns fail
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the wait for pready is bounded
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 8'h00, rd, er);
    chk(rd, exp);
  endtask

  // Bounded wait for the receive or the error request
  task automatic waitIrq(input logic err);
    int n;
    n = 0;
    while ((err ? errIrq : rxIrq) !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    // A request that never comes counts against the run
    if (n >= 400) begin
      num_errors++;
      $display("BAD %0t wait for request timed out", $time);
    end
  endtask

  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog at 20000 cycles, well beyond the expected few hundred
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    logic [31:0] rdv;
    logic erv;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0;
    selN = 1'b1;
    peerTx = 8'h00;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, rdv, erv);
      if (!rows[i].wr)
        chk(rdv, rows[i].exp);
      chk({31'h0, erv}, {31'h0, rows[i].err});
    end
    wr(SPC_OFS_CTRL, 8'h28);
    wr(SPC_OFS_STAT, 8'h01);
    $display("Register table test done");
    // Master exchange at divisor 8; select held low across bytes
    peerTx = 8'h3c;
    selN <= 1'b0;
    wr(SPC_OFS_CTRL, 8'hab);
    wr(SPC_OFS_DATA, 8'ha5);
    waitIrq(1'b0);
    rdc(SPC_OFS_STAT, 32'h89);
    chk({31'h0, txIrq}, 32'h1);
    rdc(SPC_OFS_DATA, 32'h3c);
    chk({24'h0, peerRx}, 32'ha5);
    rdc(SPC_OFS_STAT, 32'h09);
    chk({31'h0, rxIrq}, 32'h0);
    $display("Master exchange test done");
    // Second byte arrives before the first is read
    wr(SPC_OFS_STAT, 8'h41);
    peerTx = 8'h11;
    wr(SPC_OFS_DATA, 8'h01);
    waitIrq(1'b0);
    peerTx = 8'h22;
    wr(SPC_OFS_DATA, 8'h02);
    waitIrq(1'b1);
    rdc(SPC_OFS_STAT, 32'he9);
    rdc(SPC_OFS_DATA, 32'h11);
    rdc(SPC_OFS_STAT, 32'h49);
    chk({31'h0, errIrq}, 32'h0);
    $display("Overrun test done");
    // Master with fault detect while select is low
    wr(SPC_OFS_STAT, 8'h45);
    rdc(SPC_OFS_CTRL, 32'ha9);
    chk({31'h0, errIrq}, 32'h1);
    selN <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(SPC_OFS_STAT, 32'h5d);
    wr(SPC_OFS_CTRL, 8'h28);
    rdc(SPC_OFS_STAT, 32'h4d);
    $display("Mode fault test done");
    // Slave with the select pin set as a port output
    wr(SPC_OFS_STAT, 8'h00);
    wr(SPC_OFS_PORT, 8'h80);
    wr(SPC_OFS_CTRL, 8'h02);
    // The write landed at the last edge; look one edge later once the pins have moved
    @(posedge clk);
    chk({31'h0, pinOen[SPC_PIN_MISO]}, 32'h1);
    chk({31'h0, pinOen[SPC_PIN_SS]}, 32'h1);
    selN <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, pinOen[SPC_PIN_MISO]}, 32'h0);
    selN <= 1'b1;
    repeat (4) @(posedge clk);
    $display("Slave select test done");
    // Wired-or master with every port direction set to output
    wr(SPC_OFS_PORT, 8'hf0);
    wr(SPC_OFS_CTRL, 8'h26);
    @(posedge clk);
    chk({31'h0, pullupEn}, 32'h0);
    chk({31'h0, pinOen[SPC_PIN_MISO]}, 32'h1);
    chk({31'h0, pinOen[SPC_PIN_SCK]}, 32'h0);
    $display("Pin ownership test done");
    // Reset in mid-run
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(SPC_OFS_CTRL, 32'h28);
    chk({31'h0, pullupEn}, 32'h1);
    $display("Second reset test done");
    tally_and_finish();
  end
endmodule
